//--- hdl/imc_regs.sv
// Serial mode/control registers with a compact bus engine and AXI4-Lite slave
`timescale 1ns/1ps
module imc_regs
  import imc_pkg::*;
#(
  parameter int AW = 5
) (
  // Clock and reset
  input  wire logic            i_mclk,
  input  wire logic            i_nrst,
  // AXI4-Lite write
  input  wire logic [AW-1:0]   i_awaddr,
  input  wire logic            i_awvalid,
  output logic                 o_awready,
  input  wire logic [31:0]     i_wdata,
  input  wire logic [3:0]      i_wstrb,
  input  wire logic            i_wvalid,
  output logic                 o_wready,
  output logic [1:0]           o_bresp,
  output logic                 o_bvalid,
  input  wire logic            i_bready,
  // AXI4-Lite read
  input  wire logic [AW-1:0]   i_araddr,
  input  wire logic            i_arvalid,
  output logic                 o_arready,
  output logic [31:0]          o_rdata,
  output logic [1:0]           o_rresp,
  output logic                 o_rvalid,
  input  wire logic            i_rready,
  // Serial bus pins
  input  wire logic            i_scl,
  input  wire logic            i_sda,
  output imc_pins_t            o_pins,
  output logic                 o_port_func,
  // Interrupt request
  output logic                 o_irq
);

  if (AW < 5) begin : g_chk
    $error("imc_regs: AW must be at least 5");
  end

  typedef struct packed {
    logic       aw_have;
    logic [2:0] aw_idx;
    logic       w_have;
    logic [7:0] w_data;
    logic       w_en;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] mode;
    logic [7:0] saddr;
    logic [7:0] saddr2;
    logic [7:0] data;
    logic       ext;
    logic       en;
    logic       ie;
    logic       master_select;
    logic       transmit_select;
    logic       ack_check_enable;
    logic       flag;
    logic       armed;
    logic       busy;
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic       scl_q;
    logic       sda_q;
    imc_fsm_t   st;
    logic [7:0] tmr;
    logic [3:0] left;
    logic       ack_ph;
    logic       scl_low;
    logic       sda_low;
    logic [7:0] sh;
    logic       ack_rx;
  } imc_state_t;

  imc_state_t state_reg;
  imc_state_t state_next;

  // Half of the serial clock period in system clocks
  // divisor by range
  function automatic logic [7:0] half_period(input logic ext, input logic [2:0] cks);
    logic [8:0] d;
    d = DIV_TAB[{ext, cks}];
    return d[8:1];
  endfunction

  function automatic logic [3:0] frame_bits(input logic [2:0] len);
    return (len == 3'h0) ? FULL_FRAME : {1'b0, len};
  endfunction

  // Word index of a byte address, invalid when misaligned or out of range
  function automatic logic [3:0] word_idx(input logic [AW-1:0] a);
    logic ok;
    ok = (a[1:0] == 2'h0) && (a[AW-1:2] < 4);
    return {~ok, a[4:2]};
  endfunction

  always_comb begin
    imc_state_t n;
    logic       ack_fmt;
    logic       order_lsb;
    logic [7:0] half;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       req_start;
    logic       req_stop;
    logic       set_flag;
    logic       frame_go;
    logic       rd_hit;
    logic [7:0] rd_val;
    logic [3:0] ri;
    logic       done;
    n         = state_reg;
    req_start = 1'b0;
    req_stop  = 1'b0;
    set_flag  = 1'b0;
    frame_go  = 1'b0;
    done      = 1'b0;
    rd_hit    = 1'b1;
    rd_val    = 8'h00;
    ri        = 4'h0;
    // ack format unless both format bits set
    // either format bit 0 appends an acknowledge bit
    ack_fmt   = ~(state_reg.saddr[FMT_BIT] & state_reg.saddr2[FMT_BIT]);
    order_lsb = state_reg.mode[MODE_ORDER];
    half      = half_period(state_reg.ext, state_reg.mode[MODE_CKS_LO +: 3]);

    // Two-stage synchronisers, third stage for edges
    n.scl_s = {state_reg.scl_s[0], i_scl};
    n.sda_s = {state_reg.sda_s[0], i_sda};
    n.scl_q = state_reg.scl_s[1];
    n.sda_q = state_reg.sda_s[1];
    scl_rise = state_reg.scl_s[1] & ~state_reg.scl_q;
    scl_fall = ~state_reg.scl_s[1] & state_reg.scl_q;
    // start/stop seen while the clock stays high
    start_det = state_reg.scl_s[1] & state_reg.scl_q & state_reg.sda_q & ~state_reg.sda_s[1];
    stop_det  = state_reg.scl_s[1] & state_reg.scl_q & ~state_reg.sda_q & state_reg.sda_s[1];

    // Write channel: address and data taken in either order
    if (i_awvalid && !state_reg.aw_have && !state_reg.bvalid) begin
      n.aw_have = 1'b1;
      ri        = word_idx(i_awaddr);
      n.aw_idx  = ri[2:0];
      n.bresp   = ri[3] ? RESP_DECERR : RESP_OKAY;
    end
    if (i_wvalid && !state_reg.w_have && !state_reg.bvalid) begin
      n.w_have = 1'b1;
      n.w_data = i_wdata[7:0];
      n.w_en   = i_wstrb[0];
    end
    if (state_reg.bvalid && i_bready) begin
      n.bvalid = 1'b0;
    end
    if (state_reg.aw_have && state_reg.w_have && !state_reg.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bvalid  = 1'b1;
      if (state_reg.w_en && state_reg.bresp == RESP_OKAY) begin
        unique case ({state_reg.aw_idx, 2'h0})
          OFF_MODE_ADDR: begin
            // shared address; enable picks the target
            if (state_reg.en) begin
              n.mode = state_reg.w_data;
            end else begin
              n.saddr = state_reg.w_data;
            end
          end
          OFF_DATA_ADDR: begin
            if (state_reg.en) begin
              n.data   = state_reg.w_data;
              frame_go = 1'b1;
            end else begin
              n.saddr2 = state_reg.w_data;
            end
          end
          OFF_CONTROL: begin
            n.en   = state_reg.w_data[CTL_EN];
            n.ie   = state_reg.w_data[CTL_IE];
            n.master_select  = state_reg.w_data[CTL_MST];
            n.transmit_select  = state_reg.w_data[CTL_TRS];
            n.ack_check_enable = state_reg.w_data[CTL_ACK_CHECK_ENABLE];
            // software can only clear, after reading it set
            if (!state_reg.w_data[CTL_FLAG] && state_reg.armed) begin
              n.flag  = 1'b0;
              n.armed = 1'b0;
            end
            if (!state_reg.w_data[CTL_QUAL] && state_reg.en && state_reg.master_select) begin
              req_start = state_reg.w_data[CTL_BUSY];
              req_stop  = ~state_reg.w_data[CTL_BUSY];
            end
          end
          default: begin
            n.ext = state_reg.w_data[TIMER_EXT];
          end
        endcase
      end
    end

    // Read channel
    o_arready = ~state_reg.rvalid;
    if (state_reg.rvalid && i_rready) begin
      n.rvalid = 1'b0;
    end
    if (i_arvalid && !state_reg.rvalid) begin
      ri = word_idx(i_araddr);
      unique case ({ri[2:0], 2'h0})
        OFF_MODE_ADDR: rd_val = state_reg.en ? state_reg.mode : state_reg.saddr;
        OFF_DATA_ADDR: rd_val = state_reg.en ? state_reg.data : state_reg.saddr2;
        OFF_CONTROL: begin
          rd_val = {state_reg.en, state_reg.ie, state_reg.master_select, state_reg.transmit_select,
                    state_reg.ack_check_enable, state_reg.busy, state_reg.flag, 1'b1};
          // a read that sees the flag arms its clear
          if (state_reg.flag && !ri[3]) begin
            n.armed = 1'b1;
          end
        end
        default: rd_val = {1'b0, state_reg.ext, 6'h00};
      endcase
      rd_hit   = ~ri[3];
      n.rvalid = 1'b1;
      n.rdata  = rd_hit ? rd_val : 8'h00;
      n.rresp  = rd_hit ? RESP_OKAY : RESP_DECERR;
    end

    // Bus line monitor
    if (start_det) begin
      n.busy = 1'b1;
      // start condition clears the bit counter
      n.mode[MODE_LEN_LO +: 3] = 3'h0;
      n.left   = FULL_FRAME;
      n.ack_ph = 1'b0;
    end
    if (stop_det) begin
      n.busy   = 1'b0;
      set_flag = 1'b1;
    end

    // Transfer engine
    if (state_reg.tmr != 8'h00 && !(state_reg.st == ST_BHI && !state_reg.scl_s[1])) begin
      n.tmr = state_reg.tmr - 8'h01;
    end
    unique case (state_reg.st)
      ST_IDLE: begin
        // slave path has no stall state at all
        if (!state_reg.master_select && state_reg.busy) begin
          if (scl_rise && !state_reg.ack_ph) begin
            n.sh = order_lsb ? {state_reg.sda_s[1], state_reg.sh[7:1]}
                             : {state_reg.sh[6:0], state_reg.sda_s[1]};
          end
          if (scl_fall) begin
            if (state_reg.ack_ph) begin
              done = 1'b1;
            end else if (state_reg.left <= 4'h1) begin
              if (ack_fmt) begin
                n.ack_ph  = 1'b1;
                n.sda_low = ~state_reg.transmit_select;
              end else begin
                done = 1'b1;
              end
            end else begin
              n.left    = state_reg.left - 4'h1;
              n.sda_low = state_reg.transmit_select & ~(order_lsb ? state_reg.sh[0] : state_reg.sh[7]);
            end
          end
        end
        if (req_start) begin
          n.st  = ST_STA1;
          n.tmr = half;
        end
      end
      ST_STA0: begin
        n.scl_low = 1'b1;
        n.sda_low = 1'b0;
        if (state_reg.tmr == 8'h00) begin
          n.st  = ST_STA1;
          n.tmr = half;
        end
      end
      ST_STA1: begin
        n.scl_low = 1'b0;
        if (state_reg.tmr == 8'h00) begin
          n.sda_low = 1'b1;
          n.st      = ST_STA2;
          n.tmr     = half;
        end
      end
      ST_STA2: begin
        if (state_reg.tmr == 8'h00) begin
          n.scl_low = 1'b1;
          n.st      = ST_HOLD;
        end
      end
      ST_HOLD: begin
        n.scl_low = 1'b1;
        if (frame_go) begin
          // written byte is shifted from the justified end
          n.sh     = state_reg.w_data;
          n.left   = frame_bits(state_reg.mode[MODE_LEN_LO +: 3]);
          n.ack_ph = 1'b0;
          n.st     = ST_BLO;
          n.tmr    = half - 8'h01;
        end else if (req_start) begin
          n.st  = ST_STA0;
          n.tmr = half;
        end else if (req_stop) begin
          n.sda_low = 1'b1;
          n.st      = ST_STO0;
          n.tmr     = half;
        end
      end
      ST_BLO: begin
        n.scl_low = 1'b1;
        // outgoing bit taken from the chosen end
        if (state_reg.ack_ph) begin
          n.sda_low = ~state_reg.transmit_select;
        end else begin
          n.sda_low = state_reg.transmit_select & ~(order_lsb ? state_reg.sh[0] : state_reg.sh[7]);
        end
        if (state_reg.tmr == 8'h00) begin
          n.scl_low = 1'b0;
          n.st      = ST_BHI;
          // High time includes the two-cycle input delay
          n.tmr     = half - 8'h03;
        end
      end
      ST_BHI: begin
        if (state_reg.tmr == 8'h00 && state_reg.scl_s[1]) begin
          n.scl_low = 1'b1;
          n.tmr     = half - 8'h01;
          n.st      = ST_BLO;
          if (state_reg.ack_ph) begin
            n.ack_rx = state_reg.sda_s[1];
            n.sda_low = 1'b0;
            done     = 1'b1;
            n.st     = ST_HOLD;
          end else begin
            // sampled bit enters at the opposite end
            n.sh   = order_lsb ? {state_reg.sda_s[1], state_reg.sh[7:1]}
                               : {state_reg.sh[6:0], state_reg.sda_s[1]};
            n.left = state_reg.left - 4'h1;
            // frame ends after the counted data bits
            if (state_reg.left == 4'h1) begin
              if (!ack_fmt) begin
                done = 1'b1;
                n.st = ST_HOLD;
              end else if (state_reg.mode[MODE_STALL]) begin
                // flag after last data fall, clock held low
                set_flag = 1'b1;
                n.st     = ST_WAIT;
              end else begin
                n.ack_ph = 1'b1;
              end
            end
          end
        end
      end
      ST_WAIT: begin
        n.scl_low = 1'b1;
        if (!state_reg.flag) begin
          n.ack_ph = 1'b1;
          n.st     = ST_BLO;
          n.tmr    = half - 8'h01;
        end
      end
      ST_STO0: begin
        if (state_reg.tmr == 8'h00) begin
          n.scl_low = 1'b0;
          n.st      = ST_STO1;
          n.tmr     = half;
        end
      end
      ST_STO1: begin
        if (state_reg.tmr == 8'h00) begin
          n.sda_low = 1'b0;
          n.st      = ST_IDLE;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    if (done) begin
      // acknowledge completion always sets the flag
      set_flag = 1'b1;
      n.data   = n.sh;
      n.ack_ph = 1'b0;
      n.left   = FULL_FRAME;
      // counter field back to 000 after the frame
      n.mode[MODE_LEN_LO +: 3] = 3'h0;
      if (state_reg.st == ST_IDLE) begin
        n.sda_low = 1'b0;
      end
    end

    // hardware set wins over a same-cycle clear
    if (set_flag) begin
      n.flag  = 1'b1;
      n.armed = 1'b0;
    end

    // disabled interface drops all transfer state
    if (!state_reg.en) begin
      n.st      = ST_IDLE;
      n.scl_low = 1'b0;
      n.sda_low = 1'b0;
      n.ack_ph  = 1'b0;
      n.busy    = 1'b0;
      n.tmr     = 8'h00;
      n.left    = FULL_FRAME;
    end
    state_next = n;
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg        <= '0;
      state_reg.mode   <= RST_MODE;
      state_reg.saddr  <= RST_SADDR;
      state_reg.saddr2 <= RST_SADDR2;
      state_reg.data   <= RST_DATA;
      state_reg.st     <= ST_IDLE;
      state_reg.left   <= FULL_FRAME;
      state_reg.scl_s  <= 2'h3;
      state_reg.sda_s  <= 2'h3;
      state_reg.scl_q  <= 1'b1;
      state_reg.sda_q  <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_awready = ~state_reg.aw_have & ~state_reg.bvalid;
  assign o_wready  = ~state_reg.w_have & ~state_reg.bvalid;
  assign o_bvalid  = state_reg.bvalid;
  assign o_bresp   = state_reg.bresp;
  assign o_rvalid  = state_reg.rvalid;
  assign o_rresp   = state_reg.rresp;
  assign o_rdata   = {24'h000000, state_reg.rdata};

  // pins belong to the bus only while enabled
  assign o_port_func       = state_reg.en;
  assign o_pins.scl_o      = 1'b0;
  assign o_pins.sda_o      = 1'b0;
  assign o_pins.scl_oe_n   = ~(state_reg.en & state_reg.scl_low);
  assign o_pins.sda_oe_n   = ~(state_reg.en & state_reg.sda_low);

  assign o_irq = state_reg.flag & state_reg.ie;

endmodule

//--- hdl/imc_pkg.sv
// Package for the serial mode/control register block
package imc_pkg;

  // Register byte offsets
  localparam logic [4:0] OFF_MODE_ADDR = 5'h00;
  localparam logic [4:0] OFF_DATA_ADDR = 5'h04;
  localparam logic [4:0] OFF_CONTROL   = 5'h08;
  localparam logic [4:0] OFF_TIMER_CTL = 5'h0C;

  // Reset values
  localparam logic [7:0] RST_MODE      = 8'h00;
  localparam logic [7:0] RST_SADDR     = 8'h00;
  localparam logic [7:0] RST_SADDR2    = 8'h01;
  localparam logic [7:0] RST_DATA      = 8'h00;

  // Mode register fields
  localparam int MODE_ORDER  = 7;
  localparam int MODE_STALL  = 6;
  localparam int MODE_CKS_LO = 3;
  localparam int MODE_LEN_LO = 0;

  // Control register fields
  localparam int CTL_EN    = 7;
  localparam int CTL_IE    = 6;
  localparam int CTL_MST   = 5;
  localparam int CTL_TRS   = 4;
  localparam int CTL_ACK_CHECK_ENABLE  = 3;
  localparam int CTL_BUSY  = 2;
  localparam int CTL_FLAG  = 1;
  localparam int CTL_QUAL  = 0;
  localparam int TIMER_EXT = 6;
  localparam int FMT_BIT   = 0;

  localparam logic [3:0] FULL_FRAME = 4'h8;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Clock divisors indexed by {extended_clock_range, clock_divider_select}
  localparam logic [15:0][8:0] DIV_TAB = {
    9'h100, 9'h0E0, 9'h0C8, 9'h0A0, 9'h080, 9'h060, 9'h050, 9'h038,
    9'h080, 9'h070, 9'h064, 9'h050, 9'h040, 9'h030, 9'h028, 9'h01C};

  typedef enum logic [3:0] {
    ST_IDLE, ST_STA0, ST_STA1, ST_STA2, ST_HOLD, ST_BLO, ST_BHI, ST_WAIT,
    ST_STO0, ST_STO1
  } imc_fsm_t;

  // Open-drain pin drive, enables active low
  typedef struct packed {
    logic scl_o;
    logic scl_oe_n;
    logic sda_o;
    logic sda_oe_n;
  } imc_pins_t;

endpackage

//--- test/imc_regs_properties.sv
// Port checker for the serial mode/control register block
`timescale 1ns/1ps
module imc_regs_properties
  import imc_pkg::*;
(
  // Clock and reset
  input wire logic        i_mclk,
  input wire logic        i_nrst,
  // Register bus
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic [1:0]  o_bresp,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0]  o_rresp,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  // Serial pins
  input wire imc_pins_t   o_pins,
  input wire logic        o_port_func
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  sequence s_wr_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_rd_taken;
    i_arvalid && o_arready;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] o_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_rd_taken |=> o_rvalid)
    else $error("read response missing");
  a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
  a_byte_read: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_decerr_zero: assert property (o_rvalid && o_rresp == RESP_DECERR |-> o_rdata == 32'h0)
    else $error("unmapped read returned data");
  a_write_refuse: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while response pending");
  a_read_refuse: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while data pending");
  a_pins_release: assert property (!o_port_func [*2] |-> o_pins.scl_oe_n && o_pins.sda_oe_n)
    else $error("pins driven while disabled");
  a_drive_low: assert property (o_pins.scl_o == 1'b0 && o_pins.sda_o == 1'b0)
    else $error("pin driven high");
endmodule

bind imc_regs imc_regs_properties u_props (
  .i_mclk(i_mclk), .i_nrst(i_nrst), .i_awvalid(i_awvalid), .o_awready(o_awready),
  .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
  .i_bready(i_bready), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
  .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_pins(o_pins),
  .o_port_func(o_port_func));

//--- test/imc_peer.sv
// Behavioural serial-bus slave that shifts in bits and acknowledges on command
`timescale 1ns/1ps
module imc_peer (
  // Bus lines
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_low,
  // Command and observation
  input  wire logic [3:0] i_ack_at,
  output logic [3:0]      o_count,
  output logic [7:0]      o_rx
);
  initial begin
    o_sda_low = 1'b0;
    o_count = 4'h0;
    o_rx = 8'h00;
  end
  always @(negedge i_sda) begin
    if (i_scl) begin
      o_count = 4'h0;
      o_rx = 8'h00;
    end
  end
  always @(posedge i_scl) begin
    if (o_count < 4'h8) o_rx = {o_rx[6:0], i_sda};
    o_count = o_count + 4'h1;
  end
  // acknowledge held for one bit after the commanded count
  always @(negedge i_scl) begin
    o_sda_low = (i_ack_at != 4'h0) && (o_count == i_ack_at);
  end
endmodule

//--- test/imc_regs_tb.sv
// Self-checking bench for the serial mode/control register block
`timescale 1ns/1ps
module imc_regs_tb;
  import imc_pkg::*;
  logic        mclk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic        awready, wready, bvalid, arready, rvalid, port_func, irq, peer_low;
  logic [1:0]  bresp, rresp;
  imc_pins_t   pins;
  wire         scl, sda;
  logic [3:0]  ack_at, cnt;
  logic [7:0]  rx;
  int          fails, checked, cyc, last_rise, period;

  // Open-drain lines with pull-ups
  assign scl = (pins.scl_oe_n === 1'b0) ? 1'b0 : 1'b1;
  assign sda = (pins.sda_oe_n === 1'b0 || peer_low) ? 1'b0 : 1'b1;

  imc_regs u_imc_regs (
    .i_mclk(mclk), .i_nrst(nrst), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_scl(scl), .i_sda(sda),
    .o_pins(pins), .o_port_func(port_func), .o_irq(irq));
  imc_peer u_imc_peer (.i_scl(scl), .i_sda(sda), .o_sda_low(peer_low),
    .i_ack_at(ack_at), .o_count(cnt), .o_rx(rx));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;
  always @(posedge scl) begin
    period = cyc - last_rise;
    last_rise = cyc;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk(32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    chk(32'(rresp), 32'(er));
    rready <= 1'b0;
  endtask

  // Polling read also arms the flag for clearing
  task automatic wait_flag();
    logic [31:0] d;
    int          n;
    n = 0;
    do begin
      rd(OFF_CONTROL, d);
      n++;
    end while (d[CTL_FLAG] !== 1'b1 && n < 2000);
    chk(32'(d[CTL_FLAG]), 32'h1);
  endtask

  task automatic t_regs();
    logic [31:0] d;
    rd(OFF_CONTROL, d);
    chk(d, 32'h01);
    rd(OFF_MODE_ADDR, d);
    chk(d, 32'(RST_SADDR));
    rd(OFF_DATA_ADDR, d);
    chk(d, 32'(RST_SADDR2));
    rd(5'h10, d, RESP_DECERR);
    wr(5'h12, 8'hFF, RESP_DECERR);
    wr(OFF_CONTROL, 8'h82);
    rd(OFF_CONTROL, d);
    chk(d, 32'h81);
    chk(32'(port_func), 32'h1);
    rd(OFF_MODE_ADDR, d);
    chk(d, 32'(RST_MODE));
    wr(OFF_MODE_ADDR, 8'h5A);
    rd(OFF_MODE_ADDR, d);
    chk(d, 32'h5A);
    wr(OFF_CONTROL, 8'h01);
    rd(OFF_MODE_ADDR, d);
    chk(d, 32'(RST_SADDR));
    chk(32'(port_func), 32'h0);
  endtask

  // Master transmit frame; stall taken from the mode byte
  task automatic t_frame(input logic [7:0] mode, input logic [7:0] data, input logic [7:0] ie,
                         input logic [3:0] ack, input logic [7:0] exp_rx,
                         input logic [3:0] exp_cnt, input int div);
    logic [31:0] d;
    int          n;
    ack_at = ack;
    // Enable and master select must stand before the start request
    wr(OFF_CONTROL, 8'hB0 | ie);
    wr(OFF_CONTROL, 8'hB4 | ie);
    n = 0;
    while (scl !== 1'b0 && n < 1000) begin
      @(posedge mclk);
      n++;
    end
    // length written between frames, clock low
    wr(OFF_MODE_ADDR, mode);
    wr(OFF_DATA_ADDR, data);
    if (mode[MODE_STALL]) begin
      wait_flag();
      repeat (40) @(posedge mclk);
      chk(32'(cnt), 32'h8);
      chk(32'(scl), 32'h0);
      // flag seen as 1 by the poll, now written 0
      wr(OFF_CONTROL, 8'hB1 | ie);
    end
    wait_flag();
    chk(32'(irq), 32'(ie[CTL_IE]));
    chk(32'(rx), 32'(exp_rx));
    chk(32'(cnt), 32'(exp_cnt));
    if (!mode[MODE_STALL]) chk(32'(period >= div && period <= div + 4), 32'h1);
    rd(OFF_MODE_ADDR, d);
    chk(32'(d[2:0]), 32'h0);
    wr(OFF_CONTROL, 8'hB0 | ie);
    wr(OFF_CONTROL, 8'h00);
  endtask

  initial begin
    nrst = 1'b0;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    ack_at = 4'h0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    t_regs();
    t_frame(8'h00, 8'hA5, 8'h00, 4'h8, 8'hA5, 4'h9, 28);
    wr(OFF_TIMER_CTL, 8'h40);
    t_frame(8'h38, 8'h3C, 8'h40, 4'h8, 8'h3C, 4'h9, 256);
    wr(OFF_TIMER_CTL, 8'h00);
    t_frame(8'h40, 8'h81, 8'h40, 4'h8, 8'h81, 4'h9, 28);
    // LSB first only with plain synchronous format
    wr(OFF_MODE_ADDR, 8'h01);
    t_frame(8'h84, 8'h0A, 8'h00, 4'h0, 8'h05, 4'h4, 28);
    wrap_up();
  end

  // Full run needs well under this span
  initial begin
    repeat (60000) @(posedge mclk);
    fails++;
    wrap_up();
  end
endmodule
